// >>> design/amd_axis.sv
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
module amd_axis #(
  parameter int CLK_HZ = 10_000_000
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        encoder_phase_a_i,
  input  wire logic        encoder_phase_b_i,
  input  wire logic        encoder_index_i,
  input  wire logic        in_position_i,
  input  wire logic        drive_fault_i,
  input  wire logic        home_switch_i,
  input  wire logic        end_limit_pos_i,
  input  wire logic        end_limit_neg_i,
  input  wire logic        slowdown_switch_i,
  input  wire logic        position_start_switch_i,
  input  wire logic        count_capture_in_i,
  input  wire logic        count_reset_in_i,
  input  wire logic        home_done_i,
  output logic             pulse_out_o,
  output logic             dir_out_o,
  output logic             deviation_clear_out_o,
  output logic             drive_enable_out_o,
  output logic             alarm_reset_out_o
);
  import amd_pkg::*;

  typedef enum {ST_IDLE, ST_RUN, ST_WAIT_INP} amd_state_type;

  localparam int ERC_W = $clog2(AMD_ERC_CYCLES + 1);
  localparam int CW    = AMD_CNT_W;

  // Registers
  amd_state_type        state_r, state_nxt;
  logic [AMD_CFG_W-1:0] cfg_r, cfg_nxt;
  logic                 drv_en_r, drv_en_nxt;
  logic                 alm_rst_r, alm_rst_nxt;
  logic                 dir_r, dir_nxt;
  logic [CW-1:0]        move_len_r, move_len_nxt;
  logic [31:0]          period_r, period_nxt;
  logic [31:0]          str_per_r, str_per_nxt;
  logic [31:0]          tick_r, tick_nxt;
  logic [CW-1:0]        left_r, left_nxt;
  logic                 phase_r, phase_nxt;
  logic [CW-1:0]        cmd_cnt_r, cmd_cnt_nxt;
  logic [CW-1:0]        fb_cnt_r, fb_cnt_nxt;
  logic [CW-1:0]        cap_r, cap_nxt;
  logic [ERC_W-1:0]     erc_r, erc_nxt;
  logic                 a_q_r, b_q_r, pcs_q_r, cap_q_r, flt_q_r, el_q_r, home_q_r;
  logic [31:0]          prdata_nxt;
  logic [31:0]          prdata_r;

  // Decoded inputs
  logic       fault_act, home_act, index_act, el_act, emit, estop;
  logic       wr_en, rd_en, start_req;
  logic [1:0] out_mode;
  logic [2:0] fb_mode;
  logic [31:0] cur_per;
  logic       a_rise, a_fall, b_rise, b_fall;
  logic       up_ev, dn_ev;

  assign wr_en     = psel_i && penable_i && pwrite_i;
  assign rd_en     = psel_i && !penable_i && !pwrite_i;
  assign out_mode  = cfg_r[AMD_CFG_OUT_MODE +: 2];
  assign fb_mode   = cfg_r[AMD_CFG_FB_MODE +: 3];
  assign fault_act = drive_fault_i == cfg_r[AMD_CFG_ALM_POL];
  assign home_act  = home_switch_i == cfg_r[AMD_CFG_HOME_POL];
  assign index_act = encoder_index_i == cfg_r[AMD_CFG_IDX_POL];
  assign el_act    = end_limit_pos_i || end_limit_neg_i;
  assign estop     = wr_en && paddr_i == AMD_OFF_CTRL && pwdata_i[AMD_CTRL_ESTOP];
  assign start_req = (wr_en && paddr_i == AMD_OFF_CTRL && pwdata_i[AMD_CTRL_START])
                     || (position_start_switch_i && !pcs_q_r);
  // Slowdown forces the starting rate in both directions
  assign cur_per   = slowdown_switch_i ? str_per_r : period_r;
  assign a_rise    = encoder_phase_a_i && !a_q_r;
  assign a_fall    = !encoder_phase_a_i && a_q_r;
  assign b_rise    = encoder_phase_b_i && !b_q_r;
  assign b_fall    = !encoder_phase_b_i && b_q_r;

  // Pulse generator: period in clocks sets rate, count sets distance
  always_comb begin
    state_nxt = state_r;
    tick_nxt  = tick_r;
    left_nxt  = left_r;
    phase_nxt = phase_r;
    emit      = 1'b0;
    case (state_r)
      ST_IDLE: begin
        phase_nxt = 1'b0;
        if (start_req && !fault_act && !el_act && move_len_r != '0) begin
          state_nxt = ST_RUN;
          left_nxt  = move_len_r;
          tick_nxt  = '0;
        end
      end
      ST_RUN: begin
        if (fault_act || el_act || estop ||
            (wr_en && paddr_i == AMD_OFF_CTRL && pwdata_i[AMD_CTRL_STOP])) begin
          state_nxt = ST_IDLE;
          phase_nxt = 1'b0;
        end else if (tick_r >= (cur_per >> 1)) begin
          tick_nxt  = '0;
          phase_nxt = !phase_r;
          if (phase_r) begin
            emit     = 1'b1;
            left_nxt = left_r - 1'b1;
            if (left_r == {{(CW-1){1'b0}}, 1'b1})
              state_nxt = cfg_r[AMD_CFG_INP_EN] ? ST_WAIT_INP : ST_IDLE;
          end
        end else begin
          tick_nxt = tick_r + 32'h0000_0001;
        end
      end
      ST_WAIT_INP: begin
        if (in_position_i || estop) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Feedback decode
  always_comb begin
    up_ev = 1'b0;
    dn_ev = 1'b0;
    if (cfg_r[AMD_CFG_FB_INT]) begin
      up_ev = emit && !dir_r;
      dn_ev = emit && dir_r;
    end else if (fb_mode == AMD_FB_UPDN) begin
      up_ev = a_rise;
      dn_ev = b_rise;
    end else if (fb_mode == AMD_FB_X1) begin
      up_ev = a_rise && !encoder_phase_b_i;
      dn_ev = a_fall && !encoder_phase_b_i;
    end else if (fb_mode == AMD_FB_X2) begin
      up_ev = (a_rise && !encoder_phase_b_i) || (a_fall && encoder_phase_b_i);
      dn_ev = (a_fall && !encoder_phase_b_i) || (a_rise && encoder_phase_b_i);
    end else begin
      up_ev = (a_rise && !encoder_phase_b_i) || (a_fall && encoder_phase_b_i) ||
              (b_rise && encoder_phase_a_i) || (b_fall && !encoder_phase_a_i);
      dn_ev = (a_fall && !encoder_phase_b_i) || (a_rise && encoder_phase_b_i) ||
              (b_fall && encoder_phase_a_i) || (b_rise && !encoder_phase_a_i);
    end
  end

  // Counters, capture and deviation clear
  always_comb begin
    cmd_cnt_nxt = cmd_cnt_r;
    fb_cnt_nxt  = fb_cnt_r;
    cap_nxt     = cap_r;
    erc_nxt     = erc_r;
    if (emit)
      cmd_cnt_nxt = dir_r ? cmd_cnt_r - 1'b1 : cmd_cnt_r + 1'b1;
    if (up_ev && !dn_ev)
      fb_cnt_nxt = fb_cnt_r + 1'b1;
    else if (dn_ev && !up_ev)
      fb_cnt_nxt = fb_cnt_r - 1'b1;
    if (count_reset_in_i || home_done_i) begin
      cmd_cnt_nxt = '0;
      fb_cnt_nxt  = '0;
    end
    if (wr_en && paddr_i == AMD_OFF_CMD_CNT)
      cmd_cnt_nxt = pwdata_i[CW-1:0];
    if (wr_en && paddr_i == AMD_OFF_FB_CNT)
      fb_cnt_nxt = pwdata_i[CW-1:0];
    // Capture takes the pre-update value seen at the edge
    if (count_capture_in_i && !cap_q_r)
      cap_nxt = cfg_r[AMD_CFG_CAP_SEL] ? cmd_cnt_r : fb_cnt_r;
    if (erc_r != '0)
      erc_nxt = erc_r - 1'b1;
    if (home_done_i || (el_act && !el_q_r) || (fault_act && !flt_q_r) || estop)
      erc_nxt = ERC_W'(AMD_ERC_CYCLES);
  end

  // APB register file
  always_comb begin
    cfg_nxt      = cfg_r;
    drv_en_nxt   = drv_en_r;
    alm_rst_nxt  = alm_rst_r;
    dir_nxt      = dir_r;
    move_len_nxt = move_len_r;
    period_nxt   = period_r;
    str_per_nxt  = str_per_r;
    prdata_nxt   = prdata_r;
    if (wr_en) begin
      if (paddr_i == AMD_OFF_CTRL) begin
        drv_en_nxt  = pwdata_i[AMD_CTRL_DRV_EN];
        alm_rst_nxt = pwdata_i[AMD_CTRL_ALM_RST];
        // Direction only changes between moves to keep pulse trains clean
        if (state_r == ST_IDLE)
          dir_nxt = pwdata_i[AMD_CTRL_DIR];
      end else if (paddr_i == AMD_OFF_CFG) begin
        cfg_nxt = pwdata_i[AMD_CFG_W-1:0];
      end else if (paddr_i == AMD_OFF_MOVE_LEN) begin
        move_len_nxt = pwdata_i[CW-1:0];
      end else if (paddr_i == AMD_OFF_PERIOD) begin
        period_nxt = pwdata_i;
      end else if (paddr_i == AMD_OFF_STR_PER) begin
        str_per_nxt = pwdata_i;
      end
    end
    if (rd_en) begin
      if (paddr_i == AMD_OFF_CTRL)
        prdata_nxt = {26'h0, dir_r, alm_rst_r, drv_en_r, 3'h0};
      else if (paddr_i == AMD_OFF_CFG)
        prdata_nxt = {21'h0, cfg_r};
      else if (paddr_i == AMD_OFF_MOVE_LEN)
        prdata_nxt = {4'h0, move_len_r};
      else if (paddr_i == AMD_OFF_PERIOD)
        prdata_nxt = period_r;
      else if (paddr_i == AMD_OFF_STR_PER)
        prdata_nxt = str_per_r;
      else if (paddr_i == AMD_OFF_STATUS)
        prdata_nxt = {24'h0, slowdown_switch_i, end_limit_neg_i, end_limit_pos_i,
                      index_act, home_act, in_position_i, fault_act,
                      state_r != ST_IDLE};
      else if (paddr_i == AMD_OFF_CMD_CNT)
        prdata_nxt = {4'h0, cmd_cnt_r};
      else if (paddr_i == AMD_OFF_FB_CNT)
        prdata_nxt = {4'h0, fb_cnt_r};
      else if (paddr_i == AMD_OFF_CAP_CNT)
        prdata_nxt = {4'h0, cap_r};
      else
        prdata_nxt = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r    <= ST_IDLE;
      cfg_r      <= '0;
      drv_en_r   <= 1'b0;
      alm_rst_r  <= 1'b0;
      dir_r      <= 1'b0;
      move_len_r <= '0;
      period_r   <= AMD_RESET_PERIOD;
      str_per_r  <= AMD_RESET_PERIOD;
      tick_r     <= '0;
      left_r     <= '0;
      phase_r    <= 1'b0;
      cmd_cnt_r  <= '0;
      fb_cnt_r   <= '0;
      cap_r      <= '0;
      erc_r      <= '0;
      prdata_r   <= 32'h0000_0000;
      a_q_r      <= 1'b0;
      b_q_r      <= 1'b0;
      pcs_q_r    <= 1'b0;
      cap_q_r    <= 1'b0;
      flt_q_r    <= 1'b0;
      el_q_r     <= 1'b0;
      home_q_r   <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cfg_r      <= cfg_nxt;
      drv_en_r   <= drv_en_nxt;
      alm_rst_r  <= alm_rst_nxt;
      dir_r      <= dir_nxt;
      move_len_r <= move_len_nxt;
      period_r   <= period_nxt;
      str_per_r  <= str_per_nxt;
      tick_r     <= tick_nxt;
      left_r     <= left_nxt;
      phase_r    <= phase_nxt;
      cmd_cnt_r  <= cmd_cnt_nxt;
      fb_cnt_r   <= fb_cnt_nxt;
      cap_r      <= cap_nxt;
      erc_r      <= erc_nxt;
      prdata_r   <= prdata_nxt;
      a_q_r      <= encoder_phase_a_i;
      b_q_r      <= encoder_phase_b_i;
      pcs_q_r    <= position_start_switch_i;
      cap_q_r    <= count_capture_in_i;
      flt_q_r    <= fault_act;
      el_q_r     <= el_act;
      home_q_r   <= home_act;
    end
  end

  // Output shaping: bit 1 of the mode flips idle level
  logic pulse_lvl, idle_hi;
  assign pulse_lvl = phase_r && state_r == ST_RUN;
  assign idle_hi   = out_mode[1];
  always_comb begin
    if (out_mode[0]) begin
      pulse_out_o = (pulse_lvl && !dir_r) ^ idle_hi;
      dir_out_o   = (pulse_lvl && dir_r) ^ idle_hi;
    end else begin
      pulse_out_o = pulse_lvl ^ idle_hi;
      dir_out_o   = dir_r;
    end
  end

  assign deviation_clear_out_o = erc_r != '0;
  assign drive_enable_out_o    = drv_en_r;
  assign alarm_reset_out_o     = alm_rst_r;
  assign prdata_o              = prdata_r;
  assign pready_o              = 1'b1;
  assign pslverr_o             = 1'b0;

endmodule : amd_axis

// >>> design/amd_pkg.sv
package amd_pkg;

  // Register byte offsets
  localparam logic [7:0] AMD_OFF_CTRL     = 8'h00;
  localparam logic [7:0] AMD_OFF_CFG      = 8'h04;
  localparam logic [7:0] AMD_OFF_MOVE_LEN = 8'h08;
  localparam logic [7:0] AMD_OFF_PERIOD   = 8'h0C;
  localparam logic [7:0] AMD_OFF_STR_PER  = 8'h10;
  localparam logic [7:0] AMD_OFF_STATUS   = 8'h14;
  localparam logic [7:0] AMD_OFF_CMD_CNT  = 8'h18;
  localparam logic [7:0] AMD_OFF_FB_CNT   = 8'h1C;
  localparam logic [7:0] AMD_OFF_CAP_CNT  = 8'h20;

  // Control register fields (write-one pulses in bit 0 to 2)
  localparam int AMD_CTRL_START   = 0;
  localparam int AMD_CTRL_STOP    = 1;
  localparam int AMD_CTRL_ESTOP   = 2;
  localparam int AMD_CTRL_DRV_EN  = 3;
  localparam int AMD_CTRL_ALM_RST = 4;
  localparam int AMD_CTRL_DIR     = 5;

  // Configuration register fields
  localparam int AMD_CFG_OUT_MODE = 0; // 2 bits
  localparam int AMD_CFG_FB_MODE  = 2; // 3 bits
  localparam int AMD_CFG_INP_EN   = 5;
  localparam int AMD_CFG_ALM_POL  = 6;
  localparam int AMD_CFG_HOME_POL = 7;
  localparam int AMD_CFG_IDX_POL  = 8;
  localparam int AMD_CFG_FB_INT   = 9;
  localparam int AMD_CFG_CAP_SEL  = 10;

  // Status register fields
  localparam int AMD_ST_BUSY  = 0;
  localparam int AMD_ST_FAULT = 1;
  localparam int AMD_ST_INPOS = 2;
  localparam int AMD_ST_HOME  = 3;
  localparam int AMD_ST_INDEX = 4;
  localparam int AMD_ST_ELP   = 5;
  localparam int AMD_ST_ELN   = 6;
  localparam int AMD_ST_SLOW  = 7;

  localparam int         AMD_CNT_W        = 28;
  localparam int         AMD_CFG_W        = 11;
  localparam logic [1:0] AMD_FB_QUAD_PREF = 2'h1;

  // Pulse output modes: bit 1 selects line idle high
  typedef enum logic [1:0] {
    AMD_OUT_PD_LOW   = 2'h0,
    AMD_OUT_DUAL_LOW = 2'h1,
    AMD_OUT_PD_HIGH  = 2'h2,
    AMD_OUT_DUAL_HIGH = 2'h3
  } amd_out_mode_type;

  // Feedback modes
  localparam logic [2:0] AMD_FB_UPDN = 3'h0;
  localparam logic [2:0] AMD_FB_X1   = 3'h1;
  localparam logic [2:0] AMD_FB_X2   = 3'h2;
  localparam logic [2:0] AMD_FB_X4   = 3'h3;

  localparam int AMD_ERC_CYCLES = 10;
  localparam logic [31:0] AMD_RESET_PERIOD = 32'h0000_03E8;

endpackage : amd_pkg

// >>> tb/amd_axis_checker.sv
`timescale 1ns/1ps
module amd_axis_checker
  import amd_pkg::*;
#(
  parameter int CLK_HZ = 10_000_000
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        drive_fault_i,
  input wire logic        end_limit_pos_i,
  input wire logic        end_limit_neg_i,
  input wire logic        home_done_i,
  input wire logic        pulse_out_o,
  input wire logic        deviation_clear_out_o,
  input wire logic        drive_enable_out_o,
  input wire logic        alarm_reset_out_o
);
  logic [3:0] cnt_r, cnt_nxt;
  logic       pol_r, pol_nxt;
  logic       wr_ok, flt_act, lim;
  assign wr_ok   = psel_i && penable_i && pwrite_i;
  assign flt_act = drive_fault_i == pol_r;
  assign lim     = end_limit_pos_i || end_limit_neg_i;
  // Shadow of the fault polarity, since the checker sees no internals
  always_comb begin
    pol_nxt = (wr_ok && paddr_i == AMD_OFF_CFG) ? pwdata_i[AMD_CFG_ALM_POL] : pol_r;
    cnt_nxt = deviation_clear_out_o ? cnt_r + 4'h1 : 4'h0;
    if (rst_i) begin
      pol_nxt = 1'b0;
      cnt_nxt = 4'h0;
    end
  end
  always_ff @(posedge clk_i) begin
    pol_r <= pol_nxt;
    cnt_r <= cnt_nxt;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_ctrl_wr;
    wr_ok && paddr_i == AMD_OFF_CTRL;
  endsequence
  sequence s_erc;
    ##[1:3] deviation_clear_out_o;
  endsequence
  a_drv_en_follow: assert property (
    s_ctrl_wr |=> drive_enable_out_o == $past(pwdata_i[AMD_CTRL_DRV_EN]))
    else $error("drive enable output not following control write");
  a_alarm_rst_follow: assert property (
    s_ctrl_wr |=> alarm_reset_out_o == $past(pwdata_i[AMD_CTRL_ALM_RST]))
    else $error("alarm reset output not following control write");
  a_erc_on_home: assert property ($rose(home_done_i) |-> s_erc)
    else $error("no deviation clear after homing done");
  a_erc_on_estop: assert property (
    wr_ok && paddr_i == AMD_OFF_CTRL && pwdata_i[AMD_CTRL_ESTOP] |-> s_erc)
    else $error("no deviation clear after emergency stop");
  a_erc_on_limit: assert property ($rose(lim) |-> s_erc)
    else $error("no deviation clear after end limit");
  a_erc_on_fault: assert property ($rose(flt_act) |-> s_erc)
    else $error("no deviation clear after drive fault");
  a_erc_pulse_width: assert property (
    $fell(deviation_clear_out_o) |-> cnt_r == AMD_ERC_CYCLES)
    else $error("deviation clear pulse has wrong width");
  a_limit_no_pulse: assert property (lim [*3] |-> $stable(pulse_out_o))
    else $error("pulse output moving while end limit held");
  a_fault_no_pulse: assert property (flt_act [*3] |-> $stable(pulse_out_o))
    else $error("pulse output moving while drive fault active");
endmodule : amd_axis_checker

bind amd_axis amd_axis_checker #(.CLK_HZ(CLK_HZ)) chk_u (.clk_i, .rst_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .drive_fault_i, .end_limit_pos_i, .end_limit_neg_i,
  .home_done_i, .pulse_out_o, .deviation_clear_out_o, .drive_enable_out_o, .alarm_reset_out_o);

// >>> tb/amd_drv_model.sv
`timescale 1ns/1ps
module amd_drv_model #(
  parameter int INP_DLY = 20
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pulse_i,
  input  wire logic dir_i,
  input  wire logic enable_i,
  input  wire logic dual_i,
  input  wire logic updn_i,
  output logic      enc_a_o,
  output logic      enc_b_o,
  output logic      in_pos_o
);
  logic       pp_r, pd_r, ua_r, ub_r, pp_nxt, pd_nxt, ua_nxt, ub_nxt, up, dn;
  logic [1:0] q_r, q_nxt;
  logic [5:0] idle_r, idle_nxt;
  // Motor only follows pulses while its control loop is on
  always_comb begin
    up       = enable_i && pulse_i && !pp_r && (dual_i || !dir_i);
    dn       = enable_i && (dual_i ? dir_i && !pd_r : pulse_i && !pp_r && dir_i);
    pp_nxt   = pulse_i;
    pd_nxt   = dir_i;
    q_nxt    = q_r + {1'b0, up} - {1'b0, dn};
    ua_nxt   = up;
    ub_nxt   = dn;
    idle_nxt = (up || dn) ? 6'h0 : ((idle_r < INP_DLY) ? idle_r + 6'h1 : idle_r);
    if (rst_i) begin
      {pp_nxt, pd_nxt, ua_nxt, ub_nxt, q_nxt, idle_nxt} = '0;
    end
  end
  always_ff @(posedge clk_i) begin
    {pp_r, pd_r, ua_r, ub_r, q_r, idle_r} <= {pp_nxt, pd_nxt, ua_nxt, ub_nxt, q_nxt, idle_nxt};
  end
  assign enc_a_o  = updn_i ? ua_r : q_r[0] ^ q_r[1];
  assign enc_b_o  = updn_i ? ub_r : q_r[1];
  assign in_pos_o = enable_i && idle_r >= INP_DLY;
endmodule : amd_drv_model

// >>> tb/amd_axis_tb.sv
`timescale 1ns/1ps
module amd_axis_tb;
  import amd_pkg::*;
  logic        clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, q;
  logic        pready_o, pslverr_o, encoder_phase_a_i, encoder_phase_b_i, in_position_i;
  logic        encoder_index_i = 1, drive_fault_i = 1, home_switch_i = 1, end_limit_pos_i = 0;
  logic        end_limit_neg_i = 0, slowdown_switch_i = 0, position_start_switch_i = 0;
  logic        count_capture_in_i = 0, count_reset_in_i = 0, home_done_i = 0;
  logic        dual = 0, updn = 0;
  logic        pulse_out_o, dir_out_o, deviation_clear_out_o, drive_enable_out_o;
  logic        alarm_reset_out_o;
  int          miscompares = 0, compares = 0, pos_n = 0, neg_n = 0, p0, n0;
  initial forever #50 clk_i = ~clk_i;
  always @(posedge pulse_out_o) pos_n++;
  always @(posedge dir_out_o) neg_n++;
  amd_axis #(.CLK_HZ(10_000_000)) dut_u (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .encoder_phase_a_i,
    .encoder_phase_b_i, .encoder_index_i, .in_position_i, .drive_fault_i, .home_switch_i,
    .end_limit_pos_i, .end_limit_neg_i, .slowdown_switch_i, .position_start_switch_i,
    .count_capture_in_i, .count_reset_in_i, .home_done_i, .pulse_out_o, .dir_out_o,
    .deviation_clear_out_o, .drive_enable_out_o, .alarm_reset_out_o);
  amd_drv_model mdl_u (.clk_i, .rst_i, .pulse_i(pulse_out_o), .dir_i(dir_out_o),
    .enable_i(drive_enable_out_o), .dual_i(dual), .updn_i(updn),
    .enc_a_o(encoder_phase_a_i), .enc_b_o(encoder_phase_b_i), .in_pos_o(in_position_i));
  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  // Holds the request until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel_i   <= 1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      test_done();
    end
    q = prdata_o;
    psel_i    <= 0;
    penable_i <= 0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    cmp(q, e);
  endtask : chk
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      xfer(1'b0, AMD_OFF_STATUS, 32'h0);
      n++;
    end while (q[AMD_ST_BUSY] !== 1'b0 && n < 300);
    if (n >= 300) begin
      miscompares++;
      test_done();
    end
  endtask : wait_idle
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    chk(AMD_OFF_PERIOD, AMD_RESET_PERIOD);
    chk(AMD_OFF_STATUS, 32'h0);
    chk(8'h40, 32'h0);
    encoder_index_i <= 0;
    home_switch_i   <= 0;
    chk(AMD_OFF_STATUS, 32'h18);
    encoder_index_i <= 1;
    home_switch_i   <= 1;
    wr(AMD_OFF_PERIOD, 32'h4);
    wr(AMD_OFF_MOVE_LEN, 32'h4);
    wr(AMD_OFF_CFG, 32'h2C);
    p0 = pos_n;
    wr(AMD_OFF_CTRL, 32'h9);
    wait_idle();
    cmp(32'(in_position_i), 32'h1);
    cmp(pos_n - p0, 32'h4);
    chk(AMD_OFF_CMD_CNT, 32'h4);
    chk(AMD_OFF_FB_CNT, 32'h4);
    wr(AMD_OFF_CFG, 32'h1);
    dual <= 1;
    updn <= 1;
    wr(AMD_OFF_CTRL, 32'h28);
    p0 = pos_n;
    n0 = neg_n;
    wr(AMD_OFF_CTRL, 32'h29);
    wait_idle();
    cmp(32'(in_position_i), 32'h0);
    cmp(neg_n - n0, 32'h4);
    cmp(pos_n - p0, 32'h0);
    chk(AMD_OFF_CMD_CNT, 32'h0);
    chk(AMD_OFF_FB_CNT, 32'h0);
    wr(AMD_OFF_CTRL, 32'h20);
    wr(AMD_OFF_CFG, 32'h200);
    dual <= 0;
    updn <= 0;
    @(posedge clk_i);
    cmp(32'(dir_out_o), 32'h1);
    wr(AMD_OFF_CTRL, 32'h0);
    wr(AMD_OFF_MOVE_LEN, 32'h3);
    wr(AMD_OFF_CTRL, 32'h1);
    wait_idle();
    chk(AMD_OFF_FB_CNT, 32'h3);
    count_capture_in_i <= 1;
    repeat (2) @(posedge clk_i);
    count_capture_in_i <= 0;
    chk(AMD_OFF_CAP_CNT, 32'h3);
    wr(AMD_OFF_MOVE_LEN, 32'h64);
    wr(AMD_OFF_CTRL, 32'h9);
    repeat (10) @(posedge clk_i);
    drive_fault_i <= 0;
    repeat (3) @(posedge clk_i);
    p0 = pos_n;
    chk(AMD_OFF_STATUS, 32'h2);
    cmp(pos_n - p0, 32'h0);
    drive_fault_i <= 1;
    wr(AMD_OFF_CTRL, 32'h0);
    wr(AMD_OFF_CFG, 32'h40);
    p0 = pos_n;
    wr(AMD_OFF_CTRL, 32'h1);
    repeat (20) @(posedge clk_i);
    cmp(pos_n - p0, 32'h0);
    chk(AMD_OFF_STATUS, 32'h2);
    wr(AMD_OFF_CFG, 32'h0);
    end_limit_neg_i   <= 1;
    slowdown_switch_i <= 1;
    p0 = pos_n;
    wr(AMD_OFF_CTRL, 32'h1);
    repeat (20) @(posedge clk_i);
    chk(AMD_OFF_STATUS, 32'hC0);
    cmp(pos_n - p0, 32'h0);
    end_limit_neg_i   <= 0;
    slowdown_switch_i <= 0;
    wr(AMD_OFF_CTRL, 32'h1);
    repeat (10) @(posedge clk_i);
    wr(AMD_OFF_CTRL, 32'h4);
    wait_idle();
    p0 = pos_n;
    repeat (10) @(posedge clk_i);
    cmp(pos_n - p0, 32'h0);
    home_done_i <= 1;
    @(posedge clk_i);
    home_done_i <= 0;
    @(posedge clk_i);
    cmp(32'(deviation_clear_out_o), 32'h1);
    repeat (11) @(posedge clk_i);
    wr(AMD_OFF_CMD_CNT, 32'h55);
    wr(AMD_OFF_FB_CNT, 32'h66);
    count_reset_in_i <= 1;
    @(posedge clk_i);
    count_reset_in_i <= 0;
    chk(AMD_OFF_CMD_CNT, 32'h0);
    chk(AMD_OFF_FB_CNT, 32'h0);
    wr(AMD_OFF_MOVE_LEN, 32'h2);
    p0 = pos_n;
    position_start_switch_i <= 1;
    repeat (3) @(posedge clk_i);
    wait_idle();
    position_start_switch_i <= 0;
    cmp(pos_n - p0, 32'h2);
    wr(AMD_OFF_CTRL, 32'h18);
    @(posedge clk_i);
    cmp(32'(alarm_reset_out_o), 32'h1);
    cmp(32'(drive_enable_out_o), 32'h1);
    for (int m = 0; m < 4; m++) begin
      wr(AMD_OFF_CFG, 32'(m));
      @(posedge clk_i);
      cmp(32'(pulse_out_o), 32'(m >> 1));
    end
    test_done();
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    miscompares++;
    test_done();
  end
endmodule : amd_axis_tb
